// File: src/ext_bus_area_config.v
// External bus area configuration bank: per-area access states, wait
// setup, upper address pins, bus release and upper chip selects.
// Assumes a bus sequencer that pulses cycle_start and names the area.
`timescale 1ns/10ps
`default_nettype none
`include "ext_bus_cfg_defs.vh"
module ext_bus_area_config #(
   parameter AREAS = 8
) (
   input  wire       clk_sys,
   input  wire       resetn,
   input  wire       hw_standby,
   input  wire [2:0] op_mode,
   input  wire [2:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   input  wire       cycle_start,
   input  wire       cycle_internal,
   input  wire [2:0] cycle_area,
   input  wire       cycle_done,
   input  wire       wait_pin,
   output reg  [2:0] cycle_states,
   output reg  [1:0] cycle_waits,
   output reg  [1:0] cycle_wait_mode,
   output reg        cycle_pin_wait,
   output reg        cycle_wait_ctl,
   output wire       cycle_wait_hold,
   input  wire       bus_request_input,
   input  wire       bus_idle,
   output reg        bus_ack,
   output wire       bus_released,
   output wire       request_pins_as_port,
   output wire       port_a_bit_four_pin_addr,
   output wire       port_a_bit_five_pin_addr,
   output wire       port_a_bit_six_pin_addr,
   output wire [3:0] upper_cs_pin_enable
);
   wire [39:0] cfg_flat;
   wire [7:0]  area_access_state_select;
   wire [7:0]  wait_mode_and_count;
   wire [7:0]  area_wait_control_enable;
   wire [7:0]  bus_release_and_upper_address;
   wire [7:0]  upper_chip_select_output_enable;
   wire [7:0]  store_rdata;
   reg  [7:0]  wdata_eff;
   reg  [2:0]  rd_addr_reg;
   reg         rd_pending_reg;
   reg         in_cycle_reg;

   // Mode helpers
   function upper_addr_mode;
      input [2:0] m;
      begin
         upper_addr_mode = (m == 3'h3) || (m == 3'h4) || (m == 3'h6);
      end
   endfunction

   function single_chip;
      input [2:0] m;
      begin
         single_chip = (m == `MODE_SINGLE_CHIP);
      end
   endfunction

   // Write filter: locked fields keep current value
   always @* begin
      wdata_eff = reg_wdata;
      case (reg_addr)
         `OFS_BUS_RELEASE: begin
            if (!upper_addr_mode(op_mode)) begin
               wdata_eff[7:5] = bus_release_and_upper_address[7:5];
            end
         end
         default: begin
            wdata_eff = reg_wdata;
         end
      endcase
   end

   // Chip select register frozen in single-chip mode
   wire wr_allowed = reg_wr && (reg_addr < `OFS_STATUS) &&
                     !((reg_addr == `OFS_CS_ENABLE) && single_chip(op_mode));

   // Constant reload image, bank index 0 in the low byte
   wire [39:0] reset_image = {`RST_CS_ENABLE, `RST_BUS_RELEASE, `RST_WAIT_ENABLE,
                              `RST_WAIT_MODE, `RST_ACCESS_STATE};

   // Register store; reset image applied right after reset release too
   reg init_done_reg;
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         init_done_reg <= 1'b0;
      end else begin
         init_done_reg <= 1'b1;
      end
   end

   cfg_reg_file #(
      .WIDTH (8),
      .DEPTH (5),
      .AW    (3)
   ) u_store (
      .clk_sys      (clk_sys),
      .resetn       (resetn),
      .hw_standby   (hw_standby || !init_done_reg),
      .wr_addr      (reg_addr),
      .wr_data      (wdata_eff),
      .wr_en        (wr_allowed && init_done_reg),
      .rd_addr      (reg_addr),
      .rd_en        (reg_rd),
      .reset_values (reset_image),
      .rd_data      (store_rdata),
      .contents     (cfg_flat)
   );

   assign area_access_state_select        = cfg_flat[7:0];
   assign wait_mode_and_count             = cfg_flat[15:8];
   assign area_wait_control_enable        = cfg_flat[23:16];
   assign bus_release_and_upper_address   = cfg_flat[31:24];
   assign upper_chip_select_output_enable = cfg_flat[39:32];

   // Remember which register was read for the reserved-bit overlay
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rd_addr_reg    <= 3'h0;
         rd_pending_reg <= 1'b0;
      end else begin
         rd_addr_reg    <= reg_addr;
         rd_pending_reg <= reg_rd;
      end
   end

   // Read data with reserved bits forced to one; status word is live
   always @* begin
      case (rd_addr_reg)
         `OFS_WAIT_MODE:   reg_rdata = store_rdata | `RSV_WAIT_MODE;
         `OFS_BUS_RELEASE: reg_rdata = store_rdata | `RSV_BUS_RELEASE;
         `OFS_CS_ENABLE:   reg_rdata = store_rdata | `RSV_CS_ENABLE;
         `OFS_STATUS:      reg_rdata = {5'h00, in_cycle_reg, bus_released, bus_ack};
         default:          reg_rdata = store_rdata;
      endcase
      if (!rd_pending_reg) begin
         reg_rdata = 8'h00;
      end
   end

   // Per-cycle decode, latched at cycle start so a cycle never changes
   wire       ext_area = !cycle_internal && !single_chip(op_mode);
   wire       three_st = area_access_state_select[cycle_area];
   wire       wce      = area_wait_control_enable[cycle_area];
   wire [1:0] wmode    = wait_mode_and_count[`WMODE_HI:`WMODE_LO];
   wire [1:0] wcount   = wait_mode_and_count[`WCOUNT_HI:`WCOUNT_LO];

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cycle_states    <= `STATES_INTERNAL;
         cycle_waits     <= 2'h0;
         cycle_wait_mode <= `WM_NONE;
         cycle_pin_wait  <= 1'b0;
         cycle_wait_ctl  <= 1'b0;
         in_cycle_reg    <= 1'b0;
      end else if (cycle_start) begin
         in_cycle_reg <= 1'b1;
         if (!ext_area) begin
            cycle_states    <= `STATES_INTERNAL;
            cycle_waits     <= 2'h0;
            cycle_wait_mode <= `WM_NONE;
            cycle_pin_wait  <= 1'b0;
            cycle_wait_ctl  <= 1'b0;
         end else if (!three_st) begin
            cycle_states    <= `STATES_TWO;
            cycle_waits     <= 2'h0;
            cycle_wait_mode <= `WM_NONE;
            cycle_pin_wait  <= 1'b0;
            cycle_wait_ctl  <= 1'b0;
         end else if (!wce) begin
            cycle_states    <= `STATES_THREE;
            cycle_waits     <= 2'h0;
            cycle_wait_mode <= `WM_NONE;
            cycle_pin_wait  <= 1'b1;
            cycle_wait_ctl  <= 1'b0;
         end else begin
            cycle_states    <= `STATES_THREE;
            cycle_wait_mode <= wmode;
            cycle_wait_ctl  <= 1'b1;
            cycle_pin_wait  <= 1'b0;
            case (wmode)
               `WM_NONE: cycle_waits <= 2'h0;
               default:  cycle_waits <= wcount;
            endcase
         end
      end else if (cycle_done) begin
         in_cycle_reg <= 1'b0;
      end
   end

   // Pin-driven wait honoured only in pin-capable three-state cycles
   assign cycle_wait_hold = wait_pin && in_cycle_reg &&
                            (cycle_pin_wait ||
                             (cycle_wait_ctl && cycle_wait_mode[1]));

   // Bus release: acknowledge only when enabled, requested and idle
   wire bus_release_enable = bus_release_and_upper_address[`BREL_EN_BIT];
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bus_ack <= 1'b0;
      end else if (!bus_release_enable || single_chip(op_mode)) begin
         bus_ack <= 1'b0;
      end else if (bus_request_input && !in_cycle_reg && bus_idle && !cycle_start) begin
         bus_ack <= 1'b1;
      end else if (!bus_request_input) begin
         bus_ack <= 1'b0;
      end
   end
   assign bus_released         = bus_ack;
   assign request_pins_as_port = !bus_release_enable;

   // Upper address pin muxing, active when bit is clear
   assign port_a_bit_four_pin_addr = upper_addr_mode(op_mode) &&
                                     !bus_release_and_upper_address[`A23_EN_BIT];
   assign port_a_bit_five_pin_addr = upper_addr_mode(op_mode) &&
                                     !bus_release_and_upper_address[`A22_EN_BIT];
   assign port_a_bit_six_pin_addr  = upper_addr_mode(op_mode) &&
                                     !bus_release_and_upper_address[`A21_EN_BIT];

   // Upper chip select pin enables taken straight from enable register bits 7:4
   assign upper_cs_pin_enable = upper_chip_select_output_enable[7:4];
endmodule
`default_nettype wire

// File: src/ext_bus_cfg_defs.vh
// Register offsets, field positions, reset values and timing figures
// for the external bus area configuration bank.
// Assumes inclusion by bare name from the design files.
`ifndef EXT_BUS_CFG_DEFS_VH
`define EXT_BUS_CFG_DEFS_VH

// Register indices on the plain register port
`define OFS_ACCESS_STATE   3'h0
`define OFS_WAIT_MODE      3'h1
`define OFS_WAIT_ENABLE    3'h2
`define OFS_BUS_RELEASE    3'h3
`define OFS_CS_ENABLE      3'h4
`define OFS_STATUS         3'h5
`define REG_COUNT          6

// Reset values
`define RST_ACCESS_STATE   8'hFF
`define RST_WAIT_MODE      8'hF3
`define RST_WAIT_ENABLE    8'hFF
`define RST_BUS_RELEASE    8'hFE
`define RST_CS_ENABLE      8'h0F

// Read-as-one masks of reserved bits
`define RSV_WAIT_MODE      8'hF0
`define RSV_BUS_RELEASE    8'h1E
`define RSV_CS_ENABLE      8'h0F

// Field positions
`define WMODE_HI           3
`define WMODE_LO           2
`define WCOUNT_HI          1
`define WCOUNT_LO          0
`define A23_EN_BIT         7
`define A22_EN_BIT         6
`define A21_EN_BIT         5
`define BREL_EN_BIT        0

// Wait modes
`define WM_PROGRAMMABLE    2'h0
`define WM_NONE            2'h1
`define WM_PIN1            2'h2
`define WM_PIN_AUTO        2'h3

// Operating modes
`define MODE_SINGLE_CHIP   3'h7

// Base state counts
`define STATES_TWO         3'h2
`define STATES_THREE       3'h3
`define STATES_INTERNAL    3'h2

`endif

// File: src/cfg_reg_file.v
// Small register store for the configuration bank, registered read data.
// Assumes single-cycle write and read strobes, never both at once.
`timescale 1ns/10ps
`default_nettype none
module cfg_reg_file #(
   parameter WIDTH = 8,
   parameter DEPTH = 5,
   parameter AW    = 3
) (
   input  wire             clk_sys,
   input  wire             resetn,
   input  wire             hw_standby,
   input  wire [AW-1:0]    wr_addr,
   input  wire [WIDTH-1:0] wr_data,
   input  wire             wr_en,
   input  wire [AW-1:0]    rd_addr,
   input  wire             rd_en,
   input  wire [WIDTH*DEPTH-1:0] reset_values,
   output reg  [WIDTH-1:0] rd_data,
   output wire [WIDTH*DEPTH-1:0] contents
);
   reg [WIDTH-1:0] store [0:DEPTH-1];
   integer i;
   genvar g;

   // Flattened view for the decode logic
   generate
      for (g = 0; g < DEPTH; g = g + 1) begin : flat
         assign contents[g*WIDTH +: WIDTH] = store[g];
      end
   endgenerate

   // Standby reloads from constant reset values; software standby keeps all
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            store[i] <= {WIDTH{1'b0}};
         end
      end else if (hw_standby) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            store[i] <= reset_values[i*WIDTH +: WIDTH];
         end
      end else if (wr_en && (wr_addr < DEPTH)) begin
         store[wr_addr] <= wr_data;
      end
   end

   // Read data registered, one cycle after the strobe
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rd_data <= {WIDTH{1'b0}};
      end else if (rd_en) begin
         rd_data <= (rd_addr < DEPTH) ? store[rd_addr] : {WIDTH{1'b0}};
      end
   end
endmodule
`default_nettype wire

// File: dv/ext_bus_area_config_properties.sv
// Checker for the area configuration bank.
// Assumes one clock and the async active-low reset.
`timescale 1ns/10ps
`default_nettype none
module ext_bus_area_config_props (
   input wire logic       clk_sys,
   input wire logic       resetn,
   input wire logic       hw_standby,
   input wire logic [2:0] op_mode,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       cycle_start,
   input wire logic       cycle_internal,
   input wire logic [2:0] cycle_states,
   input wire logic [1:0] cycle_waits,
   input wire logic       bus_request_input,
   input wire logic       bus_ack,
   input wire logic       request_pins_as_port,
   input wire logic       port_a_bit_four_pin_addr,
   input wire logic [3:0] upper_cs_pin_enable
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Write decodes; standby excluded since it reloads everything
   wire w_rel = reg_wr && reg_addr == 3'h3 && !hw_standby;
   wire w_cs = reg_wr && reg_addr == 3'h4 && !hw_standby;
   wire a_ok = op_mode == 3'h3 || op_mode == 3'h4 || op_mode == 3'h6;
   property p_cs_wr; w_cs && op_mode != 3'h7 |=> upper_cs_pin_enable == $past(reg_wdata[7:4]); endproperty
   a_cs_wr: assert property (p_cs_wr) else $error("cs enable not written");
   property p_cs_lock; w_cs && op_mode == 3'h7 |=> $stable(upper_cs_pin_enable); endproperty
   a_cs_lock: assert property (p_cs_lock) else $error("cs enable changed");
   property p_a_wr; w_rel && a_ok |=> port_a_bit_four_pin_addr == !$past(reg_wdata[7]); endproperty
   a_a_wr: assert property (p_a_wr) else $error("upper address pin wrong");
   property p_a_lock; w_rel && !a_ok |=> $stable(port_a_bit_four_pin_addr); endproperty
   a_a_lock: assert property (p_a_lock) else $error("upper address pin changed");
   property p_rsv; reg_rd |=> ($past(reg_addr) != 3'h1 || reg_rdata[7:4] == 4'hF)
      && ($past(reg_addr) != 3'h3 || reg_rdata[4:1] == 4'hF)
      && ($past(reg_addr) != 3'h4 || reg_rdata[3:0] == 4'hF); endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits not one");
   property p_intl; cycle_start && cycle_internal |=> cycle_states == 3'h2; endproperty
   a_intl: assert property (p_intl) else $error("internal state count");
   property p_two; cycle_states == 3'h2 |-> cycle_waits == 2'h0; endproperty
   a_two: assert property (p_two) else $error("waits in two-state cycle");
   property p_hold; !cycle_start |=> $stable(cycle_states) && $stable(cycle_waits); endproperty
   a_hold: assert property (p_hold) else $error("cycle setup changed");
   property p_norel; request_pins_as_port && !bus_ack |=> !bus_ack; endproperty
   a_norel: assert property (p_norel) else $error("bus released while disabled");
   property p_drop; !bus_request_input |=> !bus_ack; endproperty
   a_drop: assert property (p_drop) else $error("ack without request");
endmodule
bind ext_bus_area_config ext_bus_area_config_props ext_bus_area_config_props_inst (.*);
`default_nettype wire

// File: dv/ext_side_model.sv
// Far side: bus sequencer, wait source and external master.
// Assumes the bench calls its tasks; moves just after clk_sys rises.
`timescale 1ns/10ps
`default_nettype none
module ext_side_model (
   input  wire logic  clk_sys,
   output logic       cycle_start,
   output logic       cycle_internal,
   output logic [2:0] cycle_area,
   output logic       cycle_done,
   output logic       wait_pin,
   output logic       bus_request_input,
   output logic       bus_idle
);
   // Quiet bus; no device stretches cycles here
   initial begin
      cycle_start = 1'b0;
      cycle_internal = 1'b0;
      cycle_area = 3'h0;
      cycle_done = 1'b0;
      wait_pin = 1'b0;
      bus_request_input = 1'b0;
      bus_idle = 1'b1;
   end
   // Opening half of a bus cycle: one-cycle start pulse
   task automatic begin_cycle(input logic [2:0] area, input logic intl);
      @(posedge clk_sys);
      cycle_start <= 1'b1;
      cycle_area <= area;
      cycle_internal <= intl;
      bus_idle <= 1'b0;
      @(posedge clk_sys);
      cycle_start <= 1'b0;
   endtask
   // Closing half: one-cycle done pulse, bus idle again
   task automatic end_cycle;
      @(posedge clk_sys);
      cycle_done <= 1'b1;
      @(posedge clk_sys);
      cycle_done <= 1'b0;
      bus_idle <= 1'b1;
   endtask
   // One bus cycle, done only after start as the sequencer would
   task automatic run_cycle(input logic [2:0] area, input logic intl);
      begin_cycle(area, intl);
      @(posedge clk_sys);
      end_cycle();
   endtask
   // External device wait request level
   task automatic set_wait(input logic v);
      @(posedge clk_sys);
      wait_pin <= v;
   endtask
   // Master request level, held until told otherwise
   task automatic set_req(input logic v);
      @(posedge clk_sys);
      bus_request_input <= v;
   endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the area configuration bank.
// Assumes the far-side model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic       clk_sys = 1'b0;
   logic       resetn = 1'b0;
   logic       hw_standby = 1'b0;
   logic [2:0] op_mode = 3'h3;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   wire  [7:0] reg_rdata;
   wire  [2:0] cycle_area, cycle_states;
   wire  [1:0] cycle_waits, cycle_wait_mode;
   wire  [3:0] upper_cs_pin_enable;
   wire        cycle_start, cycle_internal, cycle_done, wait_pin, bus_idle;
   wire        cycle_pin_wait, cycle_wait_ctl, bus_request_input, bus_ack;
   wire        bus_released, request_pins_as_port, cycle_wait_hold;
   wire        port_a_bit_four_pin_addr, port_a_bit_five_pin_addr, port_a_bit_six_pin_addr;
   wire  [2:0] pa = {port_a_bit_four_pin_addr, port_a_bit_five_pin_addr,
                     port_a_bit_six_pin_addr};
   int         num_errors = 0;
   int         n_compared = 0;
   logic [7:0] rv [5] = '{8'hFF, 8'hF3, 8'hFF, 8'hFE, 8'h0F};

   ext_bus_area_config ext_bus_area_config_inst (.*);
   ext_side_model ext_side_model_inst (.*);

   // 40 MHz system clock
   always #12.5 clk_sys = ~clk_sys;

   task automatic summarize;
      if (num_errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   // Register port: one-cycle strobes, read data in the next cycle only
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic cyc(input logic [2:0] a, input logic i);
      ext_side_model_inst.run_cycle(a, i);
      #1;
   endtask
   // Reset image of every register, unmapped index reads zero
   task automatic t_reset_vals;
      for (int i = 0; i < 5; i++) rd(3'(i), rv[i]);
      rd(3'h6, 8'h00);
   endtask
   // Reserved bits stay one after writing zeros
   task automatic t_reserved;
      wr(3'h1, 8'h00);
      wr(3'h3, 8'h00);
      wr(3'h4, 8'h00);
      rd(3'h1, 8'hF0);
      rd(3'h3, 8'h1E);
      rd(3'h4, 8'h0F);
      chk(pa, 8'h07);
   endtask
   // Every wait mode and count on a three-state area
   task automatic t_waits;
      for (int m = 0; m < 4; m++) begin
         for (int c = 0; c < 4; c++) begin
            wr(3'h1, 8'(m * 4 + c));
            cyc(3'h3, 1'b0);
            chk(cycle_wait_mode, 8'(m));
            chk(cycle_states, 8'h03);
            // Mode 01 inserts nothing; the others insert the count
            chk(cycle_waits, (m == 1) ? 8'h00 : 8'(c));
         end
      end
   endtask
   // Two-state area, disabled wait control, internal access
   task automatic t_areas;
      wr(3'h0, 8'hF7);
      wr(3'h2, 8'hEF);
      cyc(3'h3, 1'b0);
      chk(cycle_states, 8'h02);
      chk(cycle_waits, 8'h00);
      cyc(3'h4, 1'b0);
      chk(cycle_states, 8'h03);
      chk({cycle_pin_wait, cycle_wait_ctl}, 8'h02);
      cyc(3'h4, 1'b1);
      chk(cycle_states, 8'h02);
   endtask
   // Wait pin stretches pin-wait cycles only, never two-state ones
   task automatic t_wait_pin;
      ext_side_model_inst.set_wait(1'b1);
      ext_side_model_inst.begin_cycle(3'h4, 1'b0);
      #1 chk(cycle_wait_hold, 8'h01);
      ext_side_model_inst.end_cycle();
      #1 chk(cycle_wait_hold, 8'h00);
      ext_side_model_inst.begin_cycle(3'h3, 1'b0);
      #1 chk(cycle_wait_hold, 8'h00);
      ext_side_model_inst.end_cycle();
      ext_side_model_inst.set_wait(1'b0);
   endtask
   // Request ignored until release is enabled, then granted and dropped
   task automatic t_release;
      ext_side_model_inst.set_req(1'b1);
      repeat (4) @(posedge clk_sys);
      #1 chk(bus_ack, 8'h00);
      chk(request_pins_as_port, 8'h01);
      wr(3'h3, 8'h01);
      for (int i = 0; i < 4 && bus_ack !== 1'b1; i++) begin
         @(posedge clk_sys);
         #1;
      end
      chk({bus_ack, bus_released}, 8'h03);
      if (bus_ack !== 1'b1) summarize();
      ext_side_model_inst.set_req(1'b0);
      repeat (2) @(posedge clk_sys);
      #1 chk(bus_ack, 8'h00);
   endtask
   // Chip selects and upper address in allowed and locked modes
   task automatic t_pins;
      wr(3'h4, 8'hA0);
      chk(upper_cs_pin_enable, 8'h0A);
      @(posedge clk_sys);
      op_mode <= 3'h7;
      wr(3'h4, 8'h50);
      chk(upper_cs_pin_enable, 8'h0A);
      // Three-state area in single-chip mode gets the internal two-state count
      cyc(3'h4, 1'b0);
      chk({cycle_states, cycle_pin_wait}, 8'h04);
      @(posedge clk_sys);
      op_mode <= 3'h5;
      wr(3'h3, 8'hFF);
      chk(pa, 8'h00);
      rd(3'h3, 8'h1F);
      // Back in an upper-address mode the untouched enables still select A23..A21
      @(posedge clk_sys);
      op_mode <= 3'h3;
      #1 chk(pa, 8'h07);
   endtask
   // Hardware standby reloads the reset image
   task automatic t_standby;
      @(posedge clk_sys);
      hw_standby <= 1'b1;
      @(posedge clk_sys);
      hw_standby <= 1'b0;
      #1 chk({upper_cs_pin_enable, 1'b0, pa}, 8'h00);
      t_reset_vals();
   endtask

   // Reset, then every scenario in turn
   initial begin
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      t_reset_vals();
      t_reserved();
      t_waits();
      t_areas();
      t_wait_pin();
      t_release();
      t_pins();
      t_standby();
      summarize();
   end
endmodule
`default_nettype wire
